// ### verilog/spms_top.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module spms_top
  import spms_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 12
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic HSEL,
  input wire logic [AW-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CPU_IMASK,
  output logic IRQ,
  input wire logic MISO_I,
  output logic MISO_O,
  output logic MISO_OE,
  input wire logic MOSI_I,
  output logic MOSI_O,
  output logic MOSI_OE,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SS_N_I,
  output logic SS_N_O,
  output logic SS_N_OE,
  input wire logic [3:0] GPIO_OUT,
  input wire logic [3:0] GPIO_OE
);

  localparam int BW = $clog2(DW);
  localparam int EW = $clog2(2 * DW);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // bit presented on the line, by order
  function automatic logic top_bit(input logic [DW-1:0] v,
                                   input logic lsb);
    top_bit = lsb ? v[0] : v[DW-1];
  endfunction

  // shift out the presented bit, bring in the captured one
  function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] v,
                                             input logic lsb,
                                             input logic b);
    shift_in = lsb ? {b, v[DW-1:1]} : {v[DW-2:0], b};
  endfunction

  // half period in bus clocks for a rate code
  function automatic logic [4:0] half_of(input logic [1:0] r);
    case (r)
      2'b00: half_of = HALF_R0;
      2'b01: half_of = HALF_R1;
      2'b10: half_of = HALF_R2;
      default: half_of = HALF_R3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------

  spms_ctrl_t ctrl_reg; // control register
  logic dp_valid_reg; // data phase pending
  logic dp_write_reg; // pending phase is a write
  logic [AW-3:0] dp_idx_reg; // word index of pending phase
  logic ap_valid; // address phase accepted
  logic rd_stat; // status read completes
  logic wr_ctrl; // control write completes
  logic wr_data; // data write completes
  logic data_acc; // any data register access

  assign ap_valid = HSEL & HTRANS[1] & HREADY;

  // zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // capture the address phase for the following data phase
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_idx_reg <= '0;
    end else begin
      dp_valid_reg <= ap_valid;
      if (ap_valid) begin
        dp_write_reg <= HWRITE;
        dp_idx_reg <= HADDR[AW-1:2];
      end
    end
  end

  assign rd_stat = dp_valid_reg & !dp_write_reg &
                   (dp_idx_reg == IDX_STAT[AW-3:0]);
  assign wr_ctrl = dp_valid_reg & dp_write_reg &
                   (dp_idx_reg == IDX_CTRL[AW-3:0]);
  assign wr_data = dp_valid_reg & dp_write_reg &
                   (dp_idx_reg == IDX_DATA[AW-3:0]);
  assign data_acc = dp_valid_reg & (dp_idx_reg == IDX_DATA[AW-3:0]);

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= HWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------

  spms_state_t state_reg; // master clock generator
  logic [4:0] cnt_reg; // divider count within half period
  logic [EW-1:0] ecnt_reg; // master clock edges emitted
  logic sck_act_reg; // master clock, before polarity
  logic act_prev_reg; // slave clock, previous sample
  logic [BW-1:0] bitcnt_reg; // bits shifted this byte
  logic slv_prog_reg; // slave byte under way
  logic [DW-1:0] sreg_reg; // shift register
  logic cap_reg; // bit captured on phase-0 lead edge
  logic hold_reg; // phase-1 outgoing bit
  logic [DW-1:0] rbuf_reg; // read buffer
  logic busy; // transfer in progress
  logic start; // master begins a byte
  logic m_edge; // master clock edge this cycle
  logic sel_slave; // selected slave
  logic act_in; // slave clock after polarity
  logic lead; // leading clock edge
  logic trail; // trailing clock edge
  logic din; // incoming serial bit
  logic xfer_done; // last bit shifted
  logic [DW-1:0] sreg_next; // shift register after trail
  logic tx_bit; // outgoing serial bit
  logic done_flag_reg; // transfer complete
  logic write_collision_flag_flag_reg; // write collision
  logic fault_flag_reg; // mode fault

  assign busy = (state_reg == SPMS_RUN) | slv_prog_reg;
  assign start = wr_data & ctrl_reg.sys_en & ctrl_reg.master & !busy;
  // edge every half period of the chosen rate
  assign m_edge = (state_reg == SPMS_RUN) &
                  (cnt_reg == half_of(ctrl_reg.rate) - 5'h01);
  assign sel_slave = ctrl_reg.sys_en & !ctrl_reg.master & !SS_N_I;
  assign act_in = SCK_I ^ ctrl_reg.clock_polarity;
  // slave edges count only while select is low
  assign lead = (m_edge & !ecnt_reg[0]) |
                (sel_slave & !act_prev_reg & act_in);
  assign trail = (m_edge & ecnt_reg[0]) |
                 (sel_slave & act_prev_reg & !act_in);
  assign din = ctrl_reg.master ? MISO_I : MOSI_I;
  assign sreg_next = shift_in(sreg_reg, ctrl_reg.bit_order,
                              ctrl_reg.clock_phase ? din : cap_reg);
  assign xfer_done = trail & (bitcnt_reg == BW'(DW - 1));
  // order picks the end that leaves first
  assign tx_bit = ctrl_reg.clock_phase ? hold_reg :
                  top_bit(sreg_reg, ctrl_reg.bit_order);

  // master clock generator
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= SPMS_IDLE;
      cnt_reg <= '0;
      ecnt_reg <= '0;
      sck_act_reg <= 1'b0;
    end else begin
      case (state_reg)
        SPMS_IDLE: begin
          cnt_reg <= '0;
          ecnt_reg <= '0;
          sck_act_reg <= 1'b0;
          if (start) begin
            state_reg <= SPMS_RUN;
          end
        end
        SPMS_RUN: begin
          if (m_edge) begin
            cnt_reg <= '0;
            ecnt_reg <= ecnt_reg + 1'b1;
            sck_act_reg <= !sck_act_reg;
            if (ecnt_reg == EW'(2 * DW - 1)) begin
              state_reg <= SPMS_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 5'h01;
          end
          // losing master mode mid byte drops the clock
          if (!ctrl_reg.master || !ctrl_reg.sys_en) begin
            state_reg <= SPMS_IDLE;
          end
        end
        default: state_reg <= SPMS_IDLE;
      endcase
    end
  end

  // slave clock history; pins are taken as synchronous
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      act_prev_reg <= 1'b0;
    end else begin
      act_prev_reg <= act_in;
    end
  end

  // in either phase, a deselect or the last bit ends the slave byte
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      slv_prog_reg <= 1'b0;
    end else if (!sel_slave || xfer_done) begin
      slv_prog_reg <= 1'b0;
    end else if (lead) begin
      slv_prog_reg <= 1'b1;
    end
  end

  // bit counter; a deselected slave restarts its byte
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      bitcnt_reg <= '0;
    end else if (start || (!ctrl_reg.master && !sel_slave)) begin
      bitcnt_reg <= '0;
    end else if (trail) begin
      bitcnt_reg <= bitcnt_reg + 1'b1;
    end
  end

  // shift register, capture and hold bits
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sreg_reg <= '0;
      cap_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else begin
      if (wr_data && !busy) begin
        sreg_reg <= HWDATA[DW-1:0];
      end else if (trail) begin
        sreg_reg <= sreg_next;
      end
      // phase 0 samples on the lead edge
      if (lead && !ctrl_reg.clock_phase) begin
        cap_reg <= din;
      end
      // phase 1 drives on lead, sampled on trail
      if (lead && ctrl_reg.clock_phase) begin
        hold_reg <= top_bit(sreg_reg, ctrl_reg.bit_order);
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rbuf_reg <= '0;
    end else if (xfer_done && !done_flag_reg) begin
      // a pending done flag blocks the newer byte
      rbuf_reg <= sreg_next;
    end
  end

  // ----------------------------------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------------------------------

  logic done_arm_reg; // status read saw done set
  logic write_collision_flag_arm_reg; // status read saw collision set
  logic fault_arm_reg; // status read saw fault set
  logic write_collision_flag_set; // rejected data write
  logic fault_set; // select low while master

  assign write_collision_flag_set = wr_data & busy;
  assign fault_set = ctrl_reg.sys_en & ctrl_reg.master & !SS_N_I;

  // arm each clear on a status read that saw the flag
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      done_arm_reg <= 1'b0;
      write_collision_flag_arm_reg <= 1'b0;
      fault_arm_reg <= 1'b0;
    end else begin
      if (rd_stat) begin
        done_arm_reg <= done_flag_reg;
        write_collision_flag_arm_reg <= write_collision_flag_flag_reg;
        fault_arm_reg <= fault_flag_reg;
      end else begin
        if (data_acc) begin
          done_arm_reg <= 1'b0;
          write_collision_flag_arm_reg <= 1'b0;
        end
        if (wr_ctrl) begin
          fault_arm_reg <= 1'b0;
        end
      end
    end
  end

  // flag registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      done_flag_reg <= 1'b0;
      write_collision_flag_flag_reg <= 1'b0;
      fault_flag_reg <= 1'b0;
    end else begin
      // done: set, or cleared by armed data access
      if (xfer_done) begin
        done_flag_reg <= 1'b1;
      end else if (data_acc && done_arm_reg) begin
        done_flag_reg <= 1'b0;
      end
      if (write_collision_flag_set) begin
        write_collision_flag_flag_reg <= 1'b1;
      end else if (data_acc && write_collision_flag_arm_reg) begin
        write_collision_flag_flag_reg <= 1'b0;
      end
      // mode fault set; cleared by control write
      if (fault_set) begin
        fault_flag_reg <= 1'b1;
      end else if (wr_ctrl && fault_arm_reg) begin
        fault_flag_reg <= 1'b0;
      end
    end
  end

  // read mux over flops; unmapped reads give zero
  always_comb begin
    HRDATA = 32'h0000_0000;
    if (dp_valid_reg && !dp_write_reg) begin
      if (dp_idx_reg == IDX_CTRL[AW-3:0]) begin
        HRDATA[7:0] = ctrl_reg;
      end else if (dp_idx_reg == IDX_STAT[AW-3:0]) begin
        HRDATA[STAT_DONE] = done_flag_reg;
        HRDATA[STAT_WRITE_COLLISION_FLAG] = write_collision_flag_flag_reg;
        HRDATA[STAT_FAULT] = fault_flag_reg;
      end else if (dp_idx_reg == IDX_DATA[AW-3:0]) begin
        HRDATA[DW-1:0] = rbuf_reg;
      end
    end
  end

  // collision is left out of the request
  assign IRQ = ctrl_reg.irq_en & !CPU_IMASK &
               (done_flag_reg | fault_flag_reg);

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------

  // gpio owns pins while system is off
  always_comb begin
    MISO_O = GPIO_OUT[LANE_MISO];
    MISO_OE = GPIO_OE[LANE_MISO];
    MOSI_O = GPIO_OUT[LANE_MOSI];
    MOSI_OE = GPIO_OE[LANE_MOSI];
    SCK_O = GPIO_OUT[LANE_SCK];
    SCK_OE = GPIO_OE[LANE_SCK];
    SS_N_O = GPIO_OUT[LANE_SS];
    SS_N_OE = GPIO_OE[LANE_SS];
    if (ctrl_reg.sys_en) begin
      SS_N_O = 1'b1;
      SS_N_OE = 1'b0;
      MISO_O = tx_bit;
      MOSI_O = tx_bit;
      SCK_O = ctrl_reg.clock_polarity ^ sck_act_reg;
      MOSI_OE = ctrl_reg.master;
      SCK_OE = ctrl_reg.master;
      MISO_OE = !ctrl_reg.master & !SS_N_I;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_idle_clock_level: assert property (
    (state_reg == SPMS_IDLE && ctrl_reg.sys_en && ctrl_reg.master)
    |-> SCK_O == ctrl_reg.clock_polarity)
    else $error("master clock not at idle level");

  a_master_stops: assert property (
    (m_edge && ecnt_reg == EW'(2 * DW - 1))
    |=> state_reg == SPMS_IDLE && xfer_done == 1'b0)
    else $error("master did not stop after last edge");

  a_slow_rate: assert property (
    (m_edge && ctrl_reg.rate == 2'b11 && ecnt_reg != EW'(2 * DW - 1)
     && !wr_ctrl) |=> !m_edge [*8])
    else $error("divide by 32 edge too early");

  a_write_collision_flag_on_busy: assert property (
    (wr_data && busy) |=> write_collision_flag_flag_reg)
    else $error("collision flag not set");

  a_done_sets: assert property (
    xfer_done |=> done_flag_reg)
    else $error("done flag not set after byte");

  a_overrun_keep: assert property (
    (xfer_done && done_flag_reg) |=> $stable(rbuf_reg))
    else $error("overrun byte overwrote buffer");

  a_fault_sets: assert property (
    fault_set |=> fault_flag_reg)
    else $error("mode fault not flagged");

  a_slave_float: assert property (
    (ctrl_reg.sys_en && !ctrl_reg.master && SS_N_I) |-> !MISO_OE)
    else $error("unselected slave drives master-in");

  a_irq_gate: assert property (
    (ctrl_reg.irq_en && !CPU_IMASK && done_flag_reg) |-> IRQ)
    else $error("interrupt not requested");

  a_done_clear: assert property (
    (rd_stat && done_flag_reg) ##[1:2] (data_acc && !xfer_done)
    |=> !done_flag_reg)
    else $error("done flag not cleared");

  c_master_byte: cover property (start ##[1:600] xfer_done);
  c_slave_byte: cover property (sel_slave && xfer_done);
  c_overrun: cover property (xfer_done && done_flag_reg);
  c_collision: cover property (write_collision_flag_set);

endmodule

// ### verilog/spms_pkg.sv
package spms_pkg;
  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CTRL = 10'h044;
  localparam logic [9:0] IDX_STAT = 10'h045;
  localparam logic [9:0] IDX_DATA = 10'h046;

  // control reset: phase set, all else clear, rate bits zero
  localparam logic [7:0] CTRL_RST = 8'h04;

  // status bit positions
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;
  localparam int STAT_FAULT = 4;

  // half serial period in bus clocks for rate codes 00..11
  localparam logic [4:0] HALF_R0 = 5'h01;
  localparam logic [4:0] HALF_R1 = 5'h02;
  localparam logic [4:0] HALF_R2 = 5'h08;
  localparam logic [4:0] HALF_R3 = 5'h10;

  // gpio lane of each serial pin
  localparam int LANE_MISO = 0;
  localparam int LANE_MOSI = 1;
  localparam int LANE_SCK = 2;
  localparam int LANE_SS = 3;

  // control register fields, bit 7 first
  typedef struct packed {
    logic irq_en;
    logic sys_en;
    logic bit_order;
    logic master;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] rate;
  } spms_ctrl_t;

  // master clock generator states
  typedef enum logic {
    SPMS_IDLE,
    SPMS_RUN
  } spms_state_t;
endpackage

// ### verification/spms_slave_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-side serial slave, behavioural
// ----------------------------------------------------------------
module spms_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsb,
  input wire logic sel,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic eff; // shift clock with polarity removed
  int n; // bit index within the byte
  assign eff = sck ^ clock_polarity;
  function automatic logic pick(input logic [7:0] v, input int i);
    return lsb ? v[i] : v[7-i];
  endfunction
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    n = 0;
  end
  always @(posedge sel) begin
    n = 0;
    if (!clock_phase) begin
      miso = pick(tx, 0);
    end
  end
  // released line must not keep the last bit
  always @(negedge sel) miso = ~miso;
  // leading edge: phase 1 drives, phase 0 samples
  always @(posedge eff) begin
    if (sel && clock_phase) miso = pick(tx, n);
    if (sel && !clock_phase) rx[lsb ? n : 7 - n] = mosi;
  end
  // trailing edge: phase 1 samples, phase 0 shifts
  always @(negedge eff) begin
    if (sel && clock_phase) rx[lsb ? n : 7 - n] = mosi;
    if (sel) n = (n + 1) % 8;
    if (sel && !clock_phase && n != 0) miso = pick(tx, n);
  end
endmodule

// ### verification/test_serial_peripheral_master_slave.sv
`timescale 1ns/1ps
module test_serial_peripheral_master_slave;
  import spms_pkg::*;
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_STAT, 2'b00};
  localparam logic [11:0] A_DATA = {IDX_DATA, 2'b00};
  logic CLK, RSTN, HSEL, HWRITE, HREADY, CPU_IMASK, HREADYOUT, HRESP, IRQ;
  logic [11:0] HADDR;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HWDATA, HRDATA;
  logic MISO_O, MISO_OE, MOSI_O, MOSI_OE, SCK_O, SCK_OE, SS_N_O, SS_N_OE;
  logic [3:0] GPIO_OUT, GPIO_OE;
  logic tb_sck, tb_mosi, tb_ss_n, p_miso, p_clock_polarity, p_clock_phase, p_lsb, p_sel;
  logic miso_w, mosi_w, sck_w, ss_w, sck_prev;
  logic [7:0] p_tx, p_rx;
  int fail_count, checked, edges, t_first, t_last, cyc;
  // ----------------------------------------------------------------
  // pin resolution from the peripheral's enables
  // ----------------------------------------------------------------
  assign miso_w = MISO_OE ? MISO_O : p_miso;
  assign mosi_w = MOSI_OE ? MOSI_O : tb_mosi;
  assign sck_w = SCK_OE ? SCK_O : tb_sck;
  assign ss_w = SS_N_OE ? SS_N_O : tb_ss_n;
  // the one slave's ready closes every bus phase
  assign HREADY = HREADYOUT;
  spms_top i_spms_top (
    .CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HWDATA(HWDATA),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CPU_IMASK(CPU_IMASK), .IRQ(IRQ), .MISO_I(miso_w), .MISO_O(MISO_O),
    .MISO_OE(MISO_OE), .MOSI_I(mosi_w), .MOSI_O(MOSI_O),
    .MOSI_OE(MOSI_OE), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE),
    .SS_N_I(ss_w), .SS_N_O(SS_N_O), .SS_N_OE(SS_N_OE),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE));
  spms_slave_model i_spms_slave_model (
    .sck(sck_w), .mosi(mosi_w), .clock_polarity(p_clock_polarity), .clock_phase(p_clock_phase),
    .lsb(p_lsb), .sel(p_sel), .tx(p_tx), .miso(p_miso), .rx(p_rx));
  // ----------------------------------------------------------------
  // clock, serial clock edge monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (SCK_O !== sck_prev) begin
      if (edges == 0) t_first = cyc;
      t_last = cyc;
      edges++;
    end
    sck_prev = SCK_O;
  end
  // longest run is about a thousand cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one single transfer: address phase, then data phase
  task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r);
    HADDR <= a;
    HWRITE <= w;
    HTRANS <= 2'b10;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask
  task automatic wait_done(output logic [31:0] s);
    s = 32'h0;
    for (int k = 0; k < 300 && s[7] !== 1'b1; k++) bus(A_STAT, 1'b0, 0, s);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_test;
    logic [31:0] r;
    bus(A_CTRL, 1'b0, 0, r);
    check(r, 32'h04);
    check({31'h0, HRESP}, 0);
    bus(12'h000, 1'b1, 32'hff, r);
    bus(12'h000, 1'b0, 0, r);
    check(r, 32'h0);
    bus(A_CTRL, 1'b1, 32'h2b, r);
    bus(A_CTRL, 1'b0, 0, r);
    check(r, 32'h2b);
    GPIO_OUT <= 4'ha;
    GPIO_OE <= 4'hf;
    repeat (2) @(posedge CLK);
    check({SS_N_O, SCK_O, MOSI_O, MISO_O}, 4'ha);
    check({SS_N_OE, SCK_OE, MOSI_OE, MISO_OE}, 4'hf);
    $display("reset test done");
  endtask
  task automatic master_xfer(input logic [1:0] rate, input logic pol,
      input logic pha, input logic lsb, input logic [7:0] mo,
      input logic [7:0] mi);
    logic [31:0] r;
    int half;
    half = rate == 2'b00 ? 1 : rate == 2'b01 ? 2 : rate == 2'b10 ? 8 : 16;
    p_clock_polarity <= pol;
    p_clock_phase <= pha;
    p_lsb <= lsb;
    p_tx <= mi;
    bus(A_CTRL, 1'b1, {24'h0, 2'b01, lsb, 1'b1, pol, pha, rate}, r);
    repeat (3) @(posedge CLK);
    edges = 0;
    p_sel <= 1'b1;
    repeat (4) @(posedge CLK);
    check(32'(edges), 0);
    check({31'h0, SCK_O}, {31'h0, pol});
    bus(A_DATA, 1'b1, {24'h0, mo}, r);
    wait_done(r);
    check(32'(edges), 16);
    check(32'(t_last - t_first), 32'(15 * half));
    check({31'h0, SCK_O}, {31'h0, pol});
    check({24'h0, p_rx}, {24'h0, mo});
    bus(A_DATA, 1'b0, 0, r);
    check(r, {24'h0, mi});
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h0);
    p_sel <= 1'b0;
    $display("master transfer test done");
  endtask
  task automatic collision_test;
    logic [31:0] r;
    p_clock_polarity <= 1'b0;
    p_clock_phase <= 1'b0;
    p_lsb <= 1'b0;
    p_tx <= 8'h42;
    bus(A_CTRL, 1'b1, 32'hd2, r);
    repeat (3) @(posedge CLK);
    p_sel <= 1'b1;
    bus(A_DATA, 1'b1, 32'h81, r);
    repeat (4) @(posedge CLK);
    bus(A_DATA, 1'b1, 32'hff, r);
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h40);
    check({31'h0, IRQ}, 0);
    wait_done(r);
    check(r, 32'hc0);
    check({31'h0, IRQ}, 1);
    bus(A_DATA, 1'b0, 0, r);
    check(r, 32'h42);
    check({24'h0, p_rx}, 32'h81);
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h0);
    check({31'h0, IRQ}, 0);
    p_sel <= 1'b0;
    $display("collision test done");
  endtask
  task automatic overrun_test;
    logic [31:0] r;
    p_clock_phase <= 1'b1;
    p_tx <= 8'h11;
    bus(A_CTRL, 1'b1, 32'h54, r);
    repeat (3) @(posedge CLK);
    p_sel <= 1'b1;
    bus(A_DATA, 1'b1, 32'h77, r);
    repeat (40) @(posedge CLK);
    p_tx <= 8'h22;
    bus(A_DATA, 1'b1, 32'h78, r);
    repeat (40) @(posedge CLK);
    check({24'h0, p_rx}, 32'h78);
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h80);
    bus(A_DATA, 1'b0, 0, r);
    check(r, 32'h11);
    p_sel <= 1'b0;
    $display("overrun test done");
  endtask
  task automatic fault_test;
    logic [31:0] r;
    bus(A_CTRL, 1'b1, 32'hd0, r);
    tb_ss_n <= 1'b0;
    repeat (4) @(posedge CLK);
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h10);
    check({31'h0, IRQ}, 1);
    CPU_IMASK <= 1'b1;
    repeat (2) @(posedge CLK);
    check({31'h0, IRQ}, 0);
    CPU_IMASK <= 1'b0;
    tb_ss_n <= 1'b1;
    repeat (3) @(posedge CLK);
    bus(A_STAT, 1'b0, 0, r);
    bus(A_CTRL, 1'b1, 32'h50, r);
    bus(A_STAT, 1'b0, 0, r);
    check(r, 32'h0);
    check({31'h0, IRQ}, 0);
    $display("mode fault test done");
  endtask
  task automatic slave_test(input logic pha);
    logic [31:0] r;
    logic [7:0] got;
    bus(A_CTRL, 1'b1, {24'h0, 5'b01000, pha, 2'b11}, r);
    repeat (3) @(posedge CLK);
    check({SCK_OE, MOSI_OE, MISO_OE}, 3'b000);
    bus(A_DATA, 1'b1, 32'h96, r);
    tb_ss_n <= 1'b0;
    repeat (3) @(posedge CLK);
    check({31'h0, MISO_OE}, 1);
    for (int i = 7; i >= 0; i--) begin
      tb_sck <= 1'b1;
      tb_mosi <= i[0] ^ i[1] ^ 1'b0 ? 1'b1 : 1'b0;
      repeat (4) @(posedge CLK);
      got[i] = MISO_O;
      tb_sck <= 1'b0;
      repeat (4) @(posedge CLK);
    end
    tb_ss_n <= 1'b1;
    wait_done(r);
    check({24'h0, got}, 32'h96);
    check({31'h0, MISO_OE}, 0);
    bus(A_DATA, 1'b0, 0, r);
    check(r, 32'h66);
    $display("slave test done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RSTN = 1'b0;
    HSEL = 1'b1;
    HADDR = 12'h000;
    HTRANS = 2'b00;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    CPU_IMASK = 1'b0;
    GPIO_OUT = 4'h0;
    GPIO_OE = 4'h0;
    {tb_sck, tb_mosi, tb_ss_n, p_sel} = 4'b0010;
    {p_clock_polarity, p_clock_phase, p_lsb} = 3'b000;
    p_tx = 8'h00;
    {fail_count, checked, edges, cyc} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    reset_test;
    // every rate, both polarities and phases, both bit orders
    for (int i = 0; i < 4; i++) begin
      master_xfer(2'(i), i[1], i[0], i[0] ^ i[1], 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
    end
    collision_test;
    overrun_test;
    fault_test;
    slave_test(1'b1);
    slave_test(1'b0);
    complete_run;
  end
endmodule
